/* ext_interrupt_detect_ack.sv */
`timescale 1ns/1ps
`include "irq_detect_regs.svh"
module ext_interrupt_detect_ack
  import irq_detect_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     rst_b,
  input  wire irq_vec_t ext_irq_req_n,
  input  wire logic     fetch_boundary,
  input  wire irq_vec_t cpu_take,
  input  wire irq_vec_t dma_take,
  input  wire logic     ack_decode_start,
  input  wire logic     ack_read_start,
  output logic          phase1_clock,
  output irq_vec_t      irq_pending,
  output logic          irq_ack_strobe_n
);

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  irq_sync_if sync_bus ();

  irq_pin_sync u_sync
  (
    .core_clk      (core_clk),
    .rst_b         (rst_b),
    .ext_irq_req_n (ext_irq_req_n),
    .sy            (sync_bus.src)
  );

  // ****************************************************************
  // Phase-one clock divider
  // ****************************************************************
  phase_e phase_r;
  phase_e phase_nxt;
  logic   ph1_fall_en;
  logic   ph1_rise_en;

  // One core cycle per phase; each phase edge becomes a one-cycle enable.
  always_comb
  begin
    case (phase_r)
      PH_HIGH: phase_nxt = PH_LOW;
      PH_LOW:  phase_nxt = PH_HIGH;
      default: phase_nxt = PH_HIGH;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      phase_r <= PH_HIGH;
    else
      phase_r <= phase_nxt;
  end

  assign ph1_fall_en  = (phase_r == PH_HIGH);  // [RULE_03]
  assign ph1_rise_en  = (phase_r == PH_LOW);
  assign phase1_clock = (phase_r == PH_HIGH);

  // ****************************************************************
  // Request detection and pending flags
  // ****************************************************************
  irq_vec_t pend_r;
  irq_vec_t pend_nxt;
  irq_vec_t set_mask;
  irq_vec_t clr_mask;

  // Builds a mask of request lines that read the active level.
  function automatic irq_vec_t active_lines(input irq_vec_t lines_n);
    active_lines = ~(lines_n ^ {`IRQ_NUM{`IRQ_REQ_ACTIVE}});
  endfunction

  // Sampling late by one enable only delays the flag by one phase-one cycle (two core cycles); the
  // level is still present only when a requester holds it over two edges, not over one.
  always_comb
  begin
    set_mask = ph1_fall_en ? active_lines(sync_bus.req_n_sync)  // [RULE_02] [RULE_03] [RULE_07]
                           : `IRQ_PEND_RST;
    clr_mask = fetch_boundary ? (cpu_take | dma_take) : `IRQ_PEND_RST;         // [RULE_04]
    pend_nxt = (pend_r & ~clr_mask) | set_mask;  // [RULE_09] [RULE_06]
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      pend_r <= `IRQ_PEND_RST;
    else
      pend_r <= pend_nxt;
  end

  assign irq_pending = pend_r;

  // ****************************************************************
  // Acknowledge strobe
  // ****************************************************************
  logic ack_r;
  logic ack_nxt;

  // Only a phase-one rising enable may move the strobe.
  always_comb
  begin
    ack_nxt = ack_r;
    if (ph1_rise_en && ack_decode_start)
      ack_nxt = `IRQ_ACK_ACTIVE;  // [RULE_08]
    else if (ph1_rise_en && ack_read_start)
      ack_nxt = `IRQ_ACK_IDLE;    // [RULE_08]
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      ack_r <= `IRQ_ACK_IDLE;
    else
      ack_r <= ack_nxt;
  end

  assign irq_ack_strobe_n = ack_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_sync_delay;
    @(posedge core_clk) disable iff (!rst_b)
    (|set_mask) |-> ((set_mask & $past(ext_irq_req_n, 2)) == 4'h0);
  endproperty
  a_sync_delay: assert property (p_sync_delay)  // [RULE_01]
    else $error("Request set without synchronised low.");

  property p_level_held;
    @(posedge core_clk) disable iff (!rst_b)
    (!ext_irq_req_n[0] && !fetch_boundary) [*4] |=> pend_r[0];
  endproperty
  a_level_held: assert property (p_level_held)  // [RULE_02]
    else $error("Held request not registered.");

  property p_set_on_fall;
    @(posedge core_clk) disable iff (!rst_b)
    (|(pend_r & ~$past(pend_r))) |-> $past(ph1_fall_en);
  endproperty
  a_set_on_fall: assert property (p_set_on_fall)  // [RULE_03]
    else $error("Pending set off the falling edge.");

  property p_clear_at_fetch;
    @(posedge core_clk) disable iff (!rst_b)
    (|($past(pend_r) & ~pend_r)) |-> $past(fetch_boundary);
  endproperty
  a_clear_at_fetch: assert property (p_clear_at_fetch)  // [RULE_04]
    else $error("Pending cleared off a fetch boundary.");

  property p_two_cycle_rate;
    @(posedge core_clk) disable iff (!rst_b)
    ph1_fall_en |=> !ph1_fall_en ##1 ph1_fall_en;
  endproperty
  a_two_cycle_rate: assert property (p_two_cycle_rate)  // [RULE_06]
    else $error("Sampling rate not every two cycles.");

  property p_one_late;
    @(posedge core_clk) disable iff (!rst_b)
    (ph1_fall_en && !sync_bus.req_n_sync[1]) |=> pend_r[1];
  endproperty
  a_one_late: assert property (p_one_late)  // [RULE_07]
    else $error("Sampled request not flagged next cycle.");

  property p_ack_low;
    @(posedge core_clk) disable iff (!rst_b)
    $fell(irq_ack_strobe_n) |-> $past(ph1_rise_en && ack_decode_start);
  endproperty
  a_ack_low: assert property (p_ack_low)  // [RULE_08]
    else $error("Strobe fell without decode start.");

  property p_ack_high;
    @(posedge core_clk) disable iff (!rst_b)
    (ph1_rise_en && ack_read_start && !ack_decode_start) |=> irq_ack_strobe_n;
  endproperty
  a_ack_high: assert property (p_ack_high)  // [RULE_08]
    else $error("Strobe did not rise at read start.");

  property p_service_clear;
    @(posedge core_clk) disable iff (!rst_b)
    (fetch_boundary && !ph1_fall_en) |=> ((pend_r & $past(cpu_take | dma_take)) == 4'h0);
  endproperty
  a_service_clear: assert property (p_service_clear)  // [RULE_09]
    else $error("Serviced request not cleared.");

  // ****************************************************************
  // Hold, reset and strobe checks
  // ****************************************************************
  // Reset must leave no stale request behind and the strobe released.
  property p_reset_idle;
    @(posedge core_clk)
    !rst_b |=> ((pend_r == `IRQ_PEND_RST) && (irq_ack_strobe_n == `IRQ_ACK_IDLE));
  endproperty
  a_reset_idle: assert property (p_reset_idle)  // [RULE_09]
    else $error("Reset left a request or the strobe behind.");

  // A pending flag may only drop when a fetch boundary services it.
  property p_pend_hold;
    @(posedge core_clk) disable iff (!rst_b)
    !fetch_boundary |=> ((pend_r & $past(pend_r)) == $past(pend_r));
  endproperty
  a_pend_hold: assert property (p_pend_hold)  // [RULE_09]
    else $error("Pending flag dropped without service.");

  // An idle line must never raise a flag that was clear.
  property p_idle_no_set;
    @(posedge core_clk) disable iff (!rst_b)
    (ph1_fall_en && sync_bus.req_n_sync[2] && !pend_r[2]) |=> !pend_r[2];
  endproperty
  a_idle_no_set: assert property (p_idle_no_set)  // [RULE_02]
    else $error("Idle line raised a request.");

  // Take masks outside a fetch boundary must change nothing.
  property p_take_ignored;
    @(posedge core_clk) disable iff (!rst_b)
    (!fetch_boundary && !ph1_fall_en) |=> (pend_r == $past(pend_r));
  endproperty
  a_take_ignored: assert property (p_take_ignored)  // [RULE_04]
    else $error("Pending flags moved between fetch boundaries.");

  // The phase output alternates, which gives one sample every two cycles.
  property p_phase_toggle;
    @(posedge core_clk) disable iff (!rst_b)
    phase1_clock |=> !phase1_clock;
  endproperty
  a_phase_toggle: assert property (p_phase_toggle)  // [RULE_06]
    else $error("Phase output did not alternate.");

  // The strobe may only move one cycle after a phase-one rising enable.
  property p_ack_on_rise;
    @(posedge core_clk) disable iff (!rst_b)
    $changed(irq_ack_strobe_n) |-> $past(ph1_rise_en);
  endproperty
  a_ack_on_rise: assert property (p_ack_on_rise)  // [RULE_08]
    else $error("Strobe moved off a phase-one rise.");

  // A decode start wins even when a read start comes with it.
  property p_decode_wins;
    @(posedge core_clk) disable iff (!rst_b)
    (ph1_rise_en && ack_decode_start) |=> !irq_ack_strobe_n;
  endproperty
  a_decode_wins: assert property (p_decode_wins)  // [RULE_08]
    else $error("Decode start did not assert the strobe.");

endmodule

/* irq_detect_regs.svh */
// How it works
// [RULE_01] Request pins are asynchronous and pass a two-stage synchroniser first.
// [RULE_02] Requests are level-sensitive; a low level at a sampling point registers one.
// [RULE_03] Requests are sampled only at the falling edge of the phase-one clock.
// [RULE_04] Core and DMA take pending requests only at instruction-fetch boundaries.
// [RULE_05] A requester holds its pin low over one or two falling phase-one edges.
// [RULE_06] A fresh request on one pin can be taken every two phase-one cycles.
// [RULE_07] A missed sampling window delays the response by exactly one more cycle.
// [RULE_08] Acknowledge strobe goes low at decode start, high at read start, on phase-one rise.
// [RULE_09] A detected request stays pending until serviced at a fetch boundary.
`ifndef IRQ_DETECT_REGS_SVH
`define IRQ_DETECT_REGS_SVH

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define IRQ_NUM        4
`define IRQ_SYNC_RST   4'hf
`define IRQ_PEND_RST   4'h0
`define IRQ_ACK_IDLE   1'b1
`define IRQ_ACK_ACTIVE 1'b0
`define IRQ_REQ_ACTIVE 1'b0

`endif

/* irq_detect_pkg.sv */
package irq_detect_pkg;

  // Phase of the phase-one clock, derived from core_clk by a divide-by-two.
  typedef enum logic [0:0]
  {
    PH_HIGH = 1'b0,
    PH_LOW  = 1'b1
  } phase_e;

  typedef logic [3:0] irq_vec_t;

endpackage

/* irq_sync_if.sv */
`timescale 1ns/1ps
interface irq_sync_if;
  logic [3:0] req_n_sync;

  modport src (output req_n_sync);
  modport dst (input  req_n_sync);
endinterface

/* irq_pin_sync.sv */
`timescale 1ns/1ps
`include "irq_detect_regs.svh"
module irq_pin_sync
  import irq_detect_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     rst_b,
  input  wire irq_vec_t ext_irq_req_n,
  irq_sync_if.src       sy
);

  irq_vec_t stage1_r;
  irq_vec_t stage1_nxt;
  irq_vec_t stage2_r;
  irq_vec_t stage2_nxt;

  // The first stage feeds only the second, so a metastable pin cannot spread.
  always_comb
  begin
    stage1_nxt = ext_irq_req_n;  // [RULE_01]
    stage2_nxt = stage1_r;       // [RULE_01]
  end

  // Reset to idle-high so no request is seen while the chain fills.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      stage1_r <= `IRQ_SYNC_RST;
      stage2_r <= `IRQ_SYNC_RST;
    end
    else
    begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign sy.req_n_sync = stage2_r;

endmodule

/* irq_source_model.sv */
`timescale 1ns/1ps
module irq_source_model
  import irq_detect_pkg::*;
(
  input  logic     core_clk,
  output irq_vec_t req_n
);
  // ****************
  // Requesting peripherals
  // ****************
  // Pins rest high, as if pulled up, so an idle line never reads as a request.
  initial req_n = 4'hf;

  // A pulse starts on a random phase, so both sampling alignments get covered.
  // Changes stay just after an edge, so the model never races the sampling flop.
  task automatic pulse(input irq_vec_t mask, input int cyc);
    @(posedge core_clk);
    repeat ($urandom_range(1, 0)) @(posedge core_clk);
    #1 req_n = ~mask;
    repeat (cyc) @(posedge core_clk);
    #1 req_n = 4'hf;
  endtask
endmodule

/* test_ext_interrupt_detect_ack.sv */
`timescale 1ns/1ps
module test_ext_interrupt_detect_ack
  import irq_detect_pkg::*;
;
  // ****************
  // Signals and model state
  // ****************
  logic       core_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       fetch_boundary = 1'b0;
  logic       ack_decode_start = 1'b0;
  logic       ack_read_start = 1'b0;
  irq_vec_t   cpu_take = 4'h0;
  irq_vec_t   dma_take = 4'h0;
  irq_vec_t   ext_irq_req_n;
  irq_vec_t   irq_pending;
  logic       phase1_clock;
  logic       irq_ack_strobe_n;
  logic [3:0] s1 = 4'hf;
  logic [3:0] s2 = 4'hf;
  logic [3:0] pend = 4'h0;
  logic       ph = 1'b1;
  logic       ack_n = 1'b1;
  int         err_count = 0;
  int         checked = 0;
  int         cycles = 0;

  irq_source_model src_u (
    .core_clk (core_clk),
    .req_n    (ext_irq_req_n)
  );

  ext_interrupt_detect_ack dut_u (
    .core_clk         (core_clk),
    .rst_b            (rst_b),
    .ext_irq_req_n    (ext_irq_req_n),
    .fetch_boundary   (fetch_boundary),
    .cpu_take         (cpu_take),
    .dma_take         (dma_take),
    .ack_decode_start (ack_decode_start),
    .ack_read_start   (ack_read_start),
    .phase1_clock     (phase1_clock),
    .irq_pending      (irq_pending),
    .irq_ack_strobe_n (irq_ack_strobe_n)
  );

  always #50 core_clk = ~core_clk;

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Outputs still hold the last edge's values here; the model then steps with the design.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles > 1)
    begin
      chk(irq_pending, pend);
      chk({2'b0, phase1_clock, irq_ack_strobe_n}, {2'b0, ph, ack_n});
    end
    if (!rst_b)
    begin
      s1 = 4'hf;
      s2 = 4'hf;
      pend = 4'h0;
      ph = 1'b1;
      ack_n = 1'b1;
    end
    else
    begin
      pend = (pend & ~(fetch_boundary ? (cpu_take | dma_take) : 4'h0)) | (ph ? ~s2 : 4'h0);
      if (!ph && ack_decode_start)
        ack_n = 1'b0;
      else if (!ph && ack_read_start)
        ack_n = 1'b1;
      s2 = s1;
      s1 = ext_irq_req_n;
      ph = ~ph;
    end
    // The ceiling sits well past the longest scenario, so only a hang reaches it.
    if (cycles > 3000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  // Service traffic is random so that set and clear meet in the same cycle now and then.
  always @(posedge core_clk)
  begin
    #1;
    fetch_boundary = (4'($urandom) < 4'h4);
    cpu_take = 4'($urandom);
    dma_take = 4'($urandom);
  end

  // A one-cycle start may land on the wrong phase and must then be ignored.
  task automatic ack_seq(input int gap);
    @(posedge core_clk);
    #1 ack_decode_start = 1'b1;
    repeat ($urandom_range(2, 1)) @(posedge core_clk);
    #1 ack_decode_start = 1'b0;
    repeat (gap) @(posedge core_clk);
    #1 ack_read_start = 1'b1;
    repeat ($urandom_range(2, 1)) @(posedge core_clk);
    #1 ack_read_start = 1'b0;
  endtask

  // Main sequence: single lines at both pulse limits, then mixed traffic, coincident starts and a closing reset.
  initial
  begin
    void'($urandom(70309));
    repeat (2) @(posedge core_clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      src_u.pulse(4'h1 << i, 2);
      src_u.pulse(4'h1 << i, 4);
      repeat (3) @(posedge core_clk);
    end
    $display("Single line test done");
    for (int i = 0; i < 60; i++)
      fork
        src_u.pulse(4'($urandom), $urandom_range(4, 2));
        ack_seq($urandom_range(4, 1));
      join
    $display("Mixed traffic test done");
    // Both starts together: decode must win and pull the strobe low.
    @(posedge core_clk);
    #1 ack_decode_start = 1'b1;
    ack_read_start = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 ack_decode_start = 1'b0;
    ack_read_start = 1'b0;
    $display("Coincident start test done");
    @(posedge core_clk);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge core_clk);
    $display("Reset test done");
    report_and_stop();
  end
endmodule
